// ==== hw/slc_status_led.sv ====
// Status and activity LED controller with configuration port
`timescale 1ns/1ps
`default_nettype none
module slc_status_led #(
  parameter int FAST_HALF = slc_pkg::FAST_HALF_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [15:0] ioAddr,
  input wire logic ioWrStb,
  input wire logic ioRdStb,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  output logic ioRdAck,
  input wire logic sdActive,
  input wire logic sataActive,
  input wire logic [2:0] sysState,
  output logic statusRed,
  output logic statusGreen,
  output logic actYellow,
  output logic actRed
);
  import slc_pkg::*;

  // Reset release
  logic rstMeta_ff, rstSync;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_ff <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync <= rstMeta_ff;
    end
  end

  // Pin inputs through three flops, accepted when stages two and three agree
  logic [4:0] pinS1_ff, pinS2_ff, pinS3_ff, pinStable_ff, nxt_pinStable;
  always_comb begin
    nxt_pinStable = pinStable_ff;
    if (pinS2_ff == pinS3_ff) begin
      nxt_pinStable = pinS3_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      pinS1_ff <= '0;
      pinS2_ff <= '0;
      pinS3_ff <= '0;
      pinStable_ff <= '0;
    end else begin
      pinS1_ff <= {sysState, sataActive, sdActive};
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
      pinStable_ff <= nxt_pinStable;
    end
  end

  logic sdSync, sataSync;
  logic [2:0] stateSync;
  assign sdSync = pinStable_ff[0];
  assign sataSync = pinStable_ff[1];
  assign stateSync = pinStable_ff[4:2];

  // Configuration and register state
  slc_cfg_state_t cfg_ff, nxt_cfg;
  logic [7:0] index_ff, nxt_index;
  logic [7:0] devSel_ff, nxt_devSel;
  logic [7:0] activate_ff, nxt_activate;
  logic [15:0] base_ff, nxt_base;
  logic [3:0] led_ff, nxt_led;
  logic [7:0] rdData_ff, nxt_rdData;
  logic rdAck_ff, nxt_rdAck;

  logic cfgOpen, ledSel, idxWr, datWr, idxRd, datRd, ledHit;
  assign cfgOpen = (cfg_ff == CFG_OPEN) || (cfg_ff == CFG_EXIT_SEEN);
  assign ledSel = (devSel_ff == DEVICE_NUM_INDICATOR);
  assign idxWr = ioWrStb && (ioAddr == CFG_INDEX_PORT);
  assign datWr = ioWrStb && (ioAddr == CFG_DATA_PORT);
  assign idxRd = ioRdStb && (ioAddr == CFG_INDEX_PORT);
  assign datRd = ioRdStb && (ioAddr == CFG_DATA_PORT);
  // Full 16-bit match against the base
  assign ledHit = activate_ff[ACTIVATE_BIT] && (ioAddr == base_ff + LED_MODE_CONTROL_OFS);

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_index = index_ff;
    nxt_devSel = devSel_ff;
    nxt_activate = activate_ff;
    nxt_base = base_ff;
    nxt_led = led_ff;
    nxt_rdData = READ_IDLE_VALUE;
    nxt_rdAck = ioRdStb;
    // Key sequence on the index port
    if (idxWr) begin
      case (cfg_ff)
        CFG_LOCKED: begin
          if (ioWrData == KEY_FIRST) nxt_cfg = CFG_KEY_SEEN;
        end
        CFG_KEY_SEEN: begin
          if (ioWrData == KEY_SECOND) nxt_cfg = CFG_OPEN;
          else if (ioWrData != KEY_FIRST) nxt_cfg = CFG_LOCKED;
        end
        CFG_OPEN: begin
          nxt_index = ioWrData;
          if (ioWrData == KEY_SECOND) nxt_cfg = CFG_EXIT_SEEN;
        end
        default: begin
          nxt_index = ioWrData;
          if (ioWrData == KEY_FIRST) nxt_cfg = CFG_LOCKED;
          else if (ioWrData != KEY_SECOND) nxt_cfg = CFG_OPEN;
        end
      endcase
    end
    // Data port writes only while open
    if (datWr && cfgOpen) begin
      if (index_ff == IDX_DEVICE_SELECT) begin
        nxt_devSel = ioWrData;
      end else if (ledSel && index_ff == IDX_DEVICE_ACTIVATE) begin
        nxt_activate = ioWrData;
      end else if (ledSel && index_ff == IDX_IO_BASE_HIGH) begin
        nxt_base[15:8] = ioWrData;
      end else if (ledSel && index_ff == IDX_IO_BASE_LOW) begin
        nxt_base[7:0] = ioWrData;
      end
    end
    if (ioWrStb && ledHit) begin
      nxt_led = ioWrData[3:0];
    end
    // Read answers
    if (idxRd && cfgOpen) begin
      nxt_rdData = index_ff;
    end else if (datRd && cfgOpen) begin
      if (index_ff == IDX_DEVICE_SELECT) begin
        nxt_rdData = devSel_ff;
      end else if (ledSel && index_ff == IDX_DEVICE_ACTIVATE) begin
        nxt_rdData = activate_ff;
      end else if (ledSel && index_ff == IDX_IO_BASE_HIGH) begin
        nxt_rdData = base_ff[15:8];
      end else if (ledSel && index_ff == IDX_IO_BASE_LOW) begin
        nxt_rdData = base_ff[7:0];
      end
    end else if (ioRdStb && ledHit) begin
      nxt_rdData = {4'h0, led_ff};
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      cfg_ff <= CFG_LOCKED;
      index_ff <= 8'h00;
      devSel_ff <= 8'h00;
      activate_ff <= DEVICE_ACTIVATE_RST;
      base_ff <= IO_BASE_RST;
      led_ff <= LED_MODE_CONTROL_RST;
      rdData_ff <= READ_IDLE_VALUE;
      rdAck_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      index_ff <= nxt_index;
      devSel_ff <= nxt_devSel;
      activate_ff <= nxt_activate;
      base_ff <= nxt_base;
      led_ff <= nxt_led;
      rdData_ff <= nxt_rdData;
      rdAck_ff <= nxt_rdAck;
    end
  end

  assign ioRdData = rdData_ff;
  assign ioRdAck = rdAck_ff;
  // Blink phases
  logic tick, fastPhase, slowPhase, sleepPhase;
  slc_blink_gen #(
    .HALF_CYCLES(FAST_HALF)
  ) u_blink (
    .sys_clk(sys_clk),
    .rstSync(rstSync),
    .tick(tick),
    .fastPhase(fastPhase),
    .slowPhase(slowPhase),
    .sleepPhase(sleepPhase)
  );

  function automatic logic modeLit(input logic [1:0] mode, input logic fast,
                                   input logic slow);
    logic lit;
    lit = 1'b0;
    if (mode == MODE_FAST) lit = fast;
    else if (mode == MODE_SLOW) lit = slow;
    else if (mode == MODE_STEADY) lit = 1'b1;
    return lit;
  endfunction

  // Lamp outputs
  logic red_ff, nxt_red, green_ff, nxt_green, yellow_ff, nxt_yellow, actRed_ff, nxt_actRed;
  always_comb begin
    nxt_red = 1'b0;
    nxt_green = 1'b0;
    nxt_yellow = sdSync;
    nxt_actRed = sataSync;
    case (stateSync)
      SYS_POWERED: nxt_green = fastPhase;
      SYS_SELF_TEST: nxt_green = slowPhase;
      SYS_OS_LOAD: nxt_green = 1'b1;
      SYS_ACT_ERROR: nxt_red = 1'b1;
      SYS_CLEAR_CMOS: nxt_red = fastPhase;
      SYS_SOFT_OFF: begin
        nxt_red = 1'b1;
        nxt_green = 1'b1;
      end
      // Both elements share one phase so orange is seen
      SYS_SUSPEND: begin
        nxt_red = sleepPhase;
        nxt_green = sleepPhase;
      end
      default: begin
        nxt_green = modeLit(led_ff[GREEN_MODE_LSB +: 2], fastPhase, slowPhase);
        nxt_red = modeLit(led_ff[RED_MODE_LSB +: 2], fastPhase, slowPhase);
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      red_ff <= 1'b0;
      green_ff <= 1'b0;
      yellow_ff <= 1'b0;
      actRed_ff <= 1'b0;
    end else begin
      red_ff <= nxt_red;
      green_ff <= nxt_green;
      yellow_ff <= nxt_yellow;
      actRed_ff <= nxt_actRed;
    end
  end

  assign statusRed = red_ff;
  assign statusGreen = green_ff;
  assign actYellow = yellow_ff;
  assign actRed = actRed_ff;
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSync);
  chk_unlock_seq: assert property (
    (cfg_ff == CFG_LOCKED && idxWr && ioWrData == KEY_FIRST) ##1 !ioWrStb ##1
    (idxWr && ioWrData == KEY_SECOND) |=> cfgOpen)
    else $error("unlock sequence did not open configuration");

  chk_lock_exit: assert property (
    (cfg_ff == CFG_OPEN && idxWr && ioWrData == KEY_SECOND) ##1 !ioWrStb ##1
    (idxWr && ioWrData == KEY_FIRST) |=> !cfgOpen)
    else $error("exit sequence did not close configuration");

  chk_device_select: assert property (
    cfgOpen && datWr && index_ff == IDX_DEVICE_SELECT |=> devSel_ff == $past(ioWrData))
    else $error("device number not stored");

  chk_base_high: assert property (
    cfgOpen && ledSel && datWr && index_ff == IDX_IO_BASE_HIGH
    |=> base_ff[15:8] == $past(ioWrData))
    else $error("base high byte not stored");

  chk_activate_write: assert property (
    cfgOpen && ledSel && datWr && index_ff == IDX_DEVICE_ACTIVATE
    |=> activate_ff == $past(ioWrData))
    else $error("activation register not stored");

  chk_locked_ignore: assert property (
    !cfgOpen && datWr |=> $stable(devSel_ff) && $stable(activate_ff) && $stable(base_ff))
    else $error("locked write changed configuration");

  chk_led_decode: assert property (
    ioWrStb && !ledHit |=> $stable(led_ff))
    else $error("LED register written off its address");

  chk_led_read: assert property (
    ioRdStb && ledHit && !cfgOpen |=> ioRdAck && ioRdData == {4'h0, $past(led_ff)})
    else $error("LED register read value wrong");

  chk_os_green: assert property (
    stateSync == SYS_OS_LOAD |=> statusGreen && !statusRed)
    else $error("loading state not steady green");

  chk_soft_orange: assert property (
    stateSync == SYS_SOFT_OFF |=> statusGreen && statusRed)
    else $error("soft-off state not orange");

  chk_activity_map: assert property (
    sdSync && !sataSync |=> actYellow && !actRed)
    else $error("card activity not yellow");

  chk_blink_hold: assert property (
    !tick ##1 !tick |-> $stable(fastPhase))
    else $error("fast phase moved without tick");

  chk_user_steady: assert property (
    stateSync == SYS_USER && led_ff[GREEN_MODE_LSB +: 2] == MODE_STEADY
    && led_ff[RED_MODE_LSB +: 2] == MODE_OFF |=> statusGreen && !statusRed)
    else $error("user steady green not shown");

  cov_unlock: cover property (cfg_ff == CFG_KEY_SEEN ##1 cfg_ff == CFG_OPEN);
  cov_led_write: cover property (ioWrStb && ledHit);
  cov_suspend: cover property (stateSync == SYS_SUSPEND && statusRed && statusGreen);
  cov_activate: cover property ($rose(activate_ff[ACTIVATE_BIT]));
endmodule
`default_nettype wire

// ==== hw/slc_pkg.sv ====
// Constants and types shared by the status LED controller
package slc_pkg;

  // Configuration port pair and key bytes
  localparam logic [15:0] CFG_INDEX_PORT = 16'h0302;
  localparam logic [15:0] CFG_DATA_PORT = 16'h0303;
  localparam logic [7:0] KEY_FIRST = 8'h46;
  localparam logic [7:0] KEY_SECOND = 8'h57;

  // Configuration indices
  localparam logic [7:0] IDX_DEVICE_SELECT = 8'h07;
  localparam logic [7:0] IDX_DEVICE_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_IO_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_IO_BASE_LOW = 8'h61;
  localparam logic [7:0] DEVICE_NUM_INDICATOR = 8'h05;

  // Offsets relative to the programmed base
  localparam logic [15:0] LED_MODE_CONTROL_OFS = 16'h0000;

  // Reset values
  localparam logic [7:0] DEVICE_ACTIVATE_RST = 8'h00;
  localparam logic [3:0] LED_MODE_CONTROL_RST = 4'h1;
  localparam logic [15:0] IO_BASE_RST = 16'h0000;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

  // Field positions
  localparam int ACTIVATE_BIT = 0;
  localparam int GREEN_MODE_LSB = 0;
  localparam int RED_MODE_LSB = 2;

  // Per-element mode codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_FAST = 2'h1;
  localparam logic [1:0] MODE_SLOW = 2'h2;
  localparam logic [1:0] MODE_STEADY = 2'h3;

  // System state codes given by firmware logic
  localparam logic [2:0] SYS_POWERED = 3'h0;
  localparam logic [2:0] SYS_SELF_TEST = 3'h1;
  localparam logic [2:0] SYS_OS_LOAD = 3'h2;
  localparam logic [2:0] SYS_ACT_ERROR = 3'h3;
  localparam logic [2:0] SYS_CLEAR_CMOS = 3'h4;
  localparam logic [2:0] SYS_SOFT_OFF = 3'h5;
  localparam logic [2:0] SYS_SUSPEND = 3'h6;
  localparam logic [2:0] SYS_USER = 3'h7;

  // Blink timing
  localparam int CLK_HZ = 250000000;
  localparam int FAST_BLINK_HZ = 8;
  localparam int SLOW_BLINK_HZ = 1;
  localparam int SLEEP_BLINK_PERIOD_MS = 2000;
  localparam int FAST_HALF_CYCLES = CLK_HZ / (2 * FAST_BLINK_HZ);
  localparam int SLOW_TICK_RATIO = FAST_BLINK_HZ / SLOW_BLINK_HZ;
  localparam int SLEEP_TICK_RATIO = (SLEEP_BLINK_PERIOD_MS * FAST_BLINK_HZ) / 1000;

  typedef enum logic [1:0] {
    CFG_LOCKED,
    CFG_KEY_SEEN,
    CFG_OPEN,
    CFG_EXIT_SEEN
  } slc_cfg_state_t;

endpackage

// ==== hw/slc_blink_gen.sv ====
// Blink phase generator dividing the system clock
`timescale 1ns/1ps
`default_nettype none
module slc_blink_gen #(
  parameter int HALF_CYCLES = 15625000
) (
  input wire logic sys_clk,
  input wire logic rstSync,
  output logic tick,
  output logic fastPhase,
  output logic slowPhase,
  output logic sleepPhase
);
  import slc_pkg::*;

  localparam int CW = $clog2(HALF_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  logic [CW-1:0] div_ff, nxt_div;
  logic tick_ff, nxt_tick;
  logic [3:0] phase_ff, nxt_phase;

  always_comb begin
    nxt_tick = 1'b0;
    nxt_div = div_ff + 1'b1;
    nxt_phase = phase_ff;
    if (div_ff == LAST) begin
      nxt_div = '0;
      nxt_tick = 1'b1;
      nxt_phase = phase_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
      phase_ff <= '0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
      phase_ff <= nxt_phase;
    end
  end

  // Phase bits: bit0 8 Hz, bit3 1 Hz, sleep toggles every 16 ticks
  logic sleep_ff, nxt_sleep;
  always_comb begin
    nxt_sleep = sleep_ff;
    if (div_ff == LAST && phase_ff == 4'hF) begin
      nxt_sleep = ~sleep_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      sleep_ff <= 1'b0;
    end else begin
      sleep_ff <= nxt_sleep;
    end
  end

  assign tick = tick_ff;
  assign fastPhase = phase_ff[0];
  assign slowPhase = phase_ff[3];
  assign sleepPhase = sleep_ff;

endmodule
`default_nettype wire

// ==== tb/slc_host_model.sv ====
// Host software model issuing I/O port cycles to the LED controller
`timescale 1ns/1ps
`default_nettype none
module slc_host_model (
  input wire logic sys_clk,
  output logic [15:0] ioAddr,
  output logic ioWrStb,
  output logic ioRdStb,
  output logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic ioRdAck
);
  import slc_pkg::*;
  initial begin
    ioAddr = 16'h0000;
    ioWrStb = 1'b0;
    ioRdStb = 1'b0;
    ioWrData = 8'h00;
  end
  // One-cycle write strobe, lines then show inverted values
  task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    ioAddr <= addr;
    ioWrData <= data;
    ioWrStb <= 1'b1;
    @(posedge sys_clk);
    ioWrStb <= 1'b0;
    ioAddr <= ~addr;
    ioWrData <= ~data;
  endtask
  // Read strobe, address held until the answer is sampled
  task automatic io_read(input logic [15:0] addr, output logic [7:0] data, output logic ack);
    int n;
    @(posedge sys_clk);
    ioAddr <= addr;
    ioRdStb <= 1'b1;
    @(posedge sys_clk);
    ioRdStb <= 1'b0;
    ack = 1'b0;
    data = 8'h00;
    for (n = 0; n < 4 && !ack; n++) begin
      @(posedge sys_clk);
      if (ioRdAck === 1'b1) begin
        ack = 1'b1;
        data = ioRdData;
      end
    end
    ioAddr <= ~addr;
  endtask
  task automatic cfg_write(input logic [7:0] idx, input logic [7:0] data);
    io_write(CFG_INDEX_PORT, idx);
    io_write(CFG_DATA_PORT, data);
  endtask
  task automatic unlock();
    io_write(CFG_INDEX_PORT, KEY_FIRST);
    io_write(CFG_INDEX_PORT, KEY_SECOND);
  endtask
  task automatic lock();
    io_write(CFG_INDEX_PORT, KEY_SECOND);
    io_write(CFG_INDEX_PORT, KEY_FIRST);
  endtask
  task automatic select_device(input logic [7:0] num);
    cfg_write(IDX_DEVICE_SELECT, num);
  endtask
endmodule
`default_nettype wire

// ==== tb/slc_status_led_tb.sv ====
// Self-checking testbench for the status LED controller
`timescale 1ns/1ps
`default_nettype none
module slc_status_led_tb;
  import slc_pkg::*;
  localparam int FH = 4;
  localparam logic [15:0] BASE = 16'h031D;
  logic sys_clk;
  logic nrst;
  logic [15:0] ioAddr;
  logic ioWrStb;
  logic ioRdStb;
  logic [7:0] ioWrData;
  logic [7:0] ioRdData;
  logic ioRdAck;
  logic sdActive;
  logic sataActive;
  logic [2:0] sysState;
  logic statusRed;
  logic statusGreen;
  logic actYellow;
  logic actRed;
  int n_fail;
  int check_count;
  int rHi, rTog, gHi, gTog;
  logic [7:0] rdv;
  logic ack;
  logic [1:0] redTab [7] = '{MODE_OFF, MODE_OFF, MODE_OFF, MODE_STEADY, MODE_FAST,
    MODE_STEADY, MODE_SLOW};
  logic [1:0] grnTab [7] = '{MODE_FAST, MODE_SLOW, MODE_STEADY, MODE_OFF, MODE_OFF,
    MODE_STEADY, MODE_SLOW};
  int halfTab [7] = '{FH, 8 * FH, FH, FH, FH, FH, 16 * FH};
  logic [7:0] ledTab [4] = '{8'h0C, 8'h0F, 8'h09, 8'h06};
  logic [15:0] badTab [2] = '{BASE + 16'h0001, BASE ^ 16'h0100};

  slc_status_led #(.FAST_HALF(FH)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdAck(ioRdAck), .sdActive(sdActive),
    .sataActive(sataActive), .sysState(sysState), .statusRed(statusRed),
    .statusGreen(statusGreen), .actYellow(actYellow), .actRed(actRed));
  slc_host_model u_host (
    .sys_clk(sys_clk), .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdAck(ioRdAck));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [15:0] addr, input logic [7:0] exp);
    u_host.io_read(addr, rdv, ack);
    check_count++;
    if (ack !== 1'b1 || rdv !== exp) begin
      n_fail++;
      $display("wrong value at %0t: read %h at %h, expected %h", $time, rdv, addr, exp);
    end
  endtask

  task automatic cfg_chk(input logic [7:0] idx, input logic [7:0] exp);
    u_host.io_write(CFG_INDEX_PORT, idx);
    rd_chk(CFG_DATA_PORT, exp);
  endtask

  // Samples both lamp elements over 256 cycles
  task automatic meas();
    logic pr, pg;
    rHi = 0; rTog = 0; gHi = 0; gTog = 0;
    pr = statusRed;
    pg = statusGreen;
    repeat (256) begin
      @(posedge sys_clk);
      if (statusRed === 1'b1) rHi++;
      if (statusGreen === 1'b1) gHi++;
      if (statusRed !== pr) rTog++;
      if (statusGreen !== pg) gTog++;
      pr = statusRed;
      pg = statusGreen;
    end
  endtask

  task automatic chk_el(input int hi, input int tog, input logic [1:0] mode, input int half);
    bit ok;
    int e;
    e = 256 / half;
    case (mode)
      MODE_OFF: ok = (hi == 0) && (tog == 0);
      MODE_STEADY: ok = (hi == 256) && (tog == 0);
      default: ok = tog >= e - 1 && tog <= e + 1 && hi >= 128 - half && hi <= 128 + half;
    endcase
    check_count++;
    if (!ok) begin
      n_fail++;
      $display("wrong value at %0t: lamp mode %0d high %0d toggles %0d", $time, mode, hi, tog);
    end
  endtask

  task automatic chk_lamp(input logic [1:0] rm, input logic [1:0] gm, input int rh, input int gh);
    repeat (12) @(posedge sys_clk);
    meas();
    chk_el(rHi, rTog, rm, rh);
    chk_el(gHi, gTog, gm, gh);
  endtask

  function automatic int half_of(input logic [1:0] mode);
    return (mode == MODE_SLOW) ? 8 * FH : FH;
  endfunction

  initial begin
    nrst = 1'b0;
    sdActive = 1'b0;
    sataActive = 1'b0;
    sysState = SYS_USER;
    n_fail = 0;
    check_count = 0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk_lamp(MODE_OFF, MODE_FAST, FH, FH);
    u_host.io_write(CFG_INDEX_PORT, KEY_FIRST);
    u_host.io_write(CFG_INDEX_PORT, 8'h11);
    u_host.cfg_write(IDX_DEVICE_SELECT, DEVICE_NUM_INDICATOR);
    rd_chk(CFG_DATA_PORT, 8'h00);
    u_host.unlock();
    cfg_chk(IDX_DEVICE_SELECT, 8'h00);
    u_host.cfg_write(IDX_IO_BASE_HIGH, 8'hAA);
    u_host.select_device(DEVICE_NUM_INDICATOR);
    cfg_chk(IDX_DEVICE_SELECT, DEVICE_NUM_INDICATOR);
    cfg_chk(IDX_DEVICE_ACTIVATE, DEVICE_ACTIVATE_RST);
    cfg_chk(IDX_IO_BASE_HIGH, IO_BASE_RST[15:8]);
    u_host.cfg_write(IDX_IO_BASE_HIGH, BASE[15:8]);
    u_host.cfg_write(IDX_IO_BASE_LOW, BASE[7:0]);
    cfg_chk(IDX_IO_BASE_HIGH, BASE[15:8]);
    cfg_chk(IDX_IO_BASE_LOW, BASE[7:0]);
    rd_chk(CFG_INDEX_PORT, IDX_IO_BASE_LOW);
    rd_chk(BASE, 8'h00);
    u_host.cfg_write(IDX_DEVICE_ACTIVATE, 8'h01);
    cfg_chk(IDX_DEVICE_ACTIVATE, 8'h01);
    u_host.lock();
    u_host.cfg_write(IDX_DEVICE_ACTIVATE, 8'h00);
    rd_chk(BASE, {4'h0, LED_MODE_CONTROL_RST});
    u_host.io_write(BASE, 8'hFF);
    rd_chk(BASE, 8'h0F);
    for (int i = 0; i < 2; i++) begin
      u_host.io_write(badTab[i], 8'h00);
      rd_chk(BASE, 8'h0F);
      rd_chk(badTab[i], 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      u_host.io_write(BASE, ledTab[i]);
      chk_lamp(ledTab[i][3:2], ledTab[i][1:0], half_of(ledTab[i][3:2]),
        half_of(ledTab[i][1:0]));
    end
    for (int s = 0; s < 7; s++) begin
      @(posedge sys_clk);
      sysState <= 3'(s);
      chk_lamp(redTab[s], grnTab[s], halfTab[s], halfTab[s]);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      sdActive <= i[0];
      sataActive <= i[1];
      repeat (8) @(posedge sys_clk);
      check_count++;
      if (actYellow !== i[0] || actRed !== i[1]) begin
        n_fail++;
        $display("wrong value at %0t: activity lamp for input %0d", $time, i);
      end
    end
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    $display("wrong value at %0t: run did not complete in time", $time);
    finish_test();
  end
endmodule
`default_nettype wire
